// ### hdl/srs_top.sv
`timescale 1ns/1ps
`default_nettype none
module srs_top #(
	parameter int unsigned CYC_MS = srs_pkg::CLK_KHZ
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic cfg_load,
	input wire logic [15:0] pressure_acq_period,
	input wire logic [15:0] analog_acq_period,
	input wire srs_pkg::srs_chan_cfg_s pressure_cfg,
	input wire srs_pkg::srs_chan_cfg_s analog_cfg,
	input wire logic [15:0] keepalive_period,
	input wire logic [7:0] terminal_one_config,
	input wire logic [7:0] terminal_one_event_count,
	input wire logic [7:0] terminal_two_config,
	input wire logic [7:0] terminal_two_event_count,
	input wire logic [1:0] sample_valid,
	input wire logic [15:0] pressure_sample,
	input wire logic [15:0] analog_sample,
	input wire logic dl_valid,
	input wire logic [7:0] dl_code,
	input wire logic dl_out_valid,
	input wire logic dl_out_term,
	input wire logic dl_out_state,
	input wire logic magnet_in,
	input wire logic [1:0] term_in,
	output logic [1:0] term_out,
	output logic [1:0] term_oe,
	output logic [1:0] acq_req,
	output logic [1:0] backup_strobe,
	output logic [1:0] alarm_active,
	output srs_pkg::srs_frame_s frame
);
	import srs_pkg::*;
	// ----------------------------------------
	// Time base
	// ----------------------------------------
	logic [23:0] ms_cnt_r;
	logic [10:0] base_cnt_r;
	logic [2:0] ka_sub_r;
	wire logic tick_ms;
	wire logic tick_2s;
	wire logic tick_10s;
	// Millisecond tick drives every slow counter
	assign tick_ms = ms_cnt_r == 24'(CYC_MS - 1);
	assign tick_2s = tick_ms && (base_cnt_r == 11'(BASE_MS - 1));
	assign tick_10s = tick_2s && (ka_sub_r == 3'(KA_BASES - 1));
	// Cascaded dividers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ms_cnt_r <= 24'h000000;
			base_cnt_r <= 11'h000;
			ka_sub_r <= 3'h0;
		end else begin
			ms_cnt_r <= tick_ms ? 24'h000000 : ms_cnt_r + 24'h000001;
			if (tick_ms)
				base_cnt_r <= tick_2s ? 11'h000 : base_cnt_r + 11'h001;
			if (tick_2s)
				ka_sub_r <= tick_10s ? 3'h0 : ka_sub_r + 3'h1;
		end
	end
	// ----------------------------------------
	// Measurement channels
	// ----------------------------------------
	srs_chan_cfg_s ch_cfg [2];
	wire logic [15:0] ch_smp [2];
	wire logic [15:0] ch_acq_in [2];
	wire logic [1:0] acq_hit;
	wire logic [1:0] bk_hit;
	wire logic [1:0] tx_hit;
	wire logic [1:0] alm_evt;
	wire logic [1:0] alm_act;
	assign ch_cfg[0] = pressure_cfg;
	assign ch_cfg[1] = analog_cfg;
	assign ch_smp[0] = pressure_sample;
	assign ch_smp[1] = analog_sample;
	assign ch_acq_in[0] = pressure_acq_period;
	assign ch_acq_in[1] = analog_acq_period;
	for (genvar c = 0; c < 2; c++) begin : g_ch
		logic [15:0] acq_r;
		logic [15:0] acq_cnt_r;
		logic [7:0] bk_cnt_r;
		logic [7:0] tx_cnt_r;
		logic lo_alm_r;
		logic hi_alm_r;
		wire logic acq_en;
		wire logic smp_ok;
		wire logic [7:0] bk_n;
		wire logic tx_en;
		wire logic lo_en;
		wire logic hi_en;
		wire logic [16:0] v;
		wire logic [16:0] lo_top;
		wire logic [16:0] hi_bot;
		wire logic lo_set;
		wire logic lo_clr;
		wire logic hi_set;
		wire logic hi_clr;
		// Zero period switches the whole channel off
		assign acq_en = acq_r != 16'h0000;
		assign acq_hit[c] = acq_en && tick_2s && (acq_cnt_r >= acq_r - 16'h0001);
		assign smp_ok = sample_valid[c] && acq_en;
		// A count of zero is treated as one so records never stall
		assign bk_n = (ch_cfg[c].backup_count == 8'h00) ? 8'h01 : ch_cfg[c].backup_count;
		assign bk_hit[c] = smp_ok && (bk_cnt_r >= bk_n - 8'h01);
		assign tx_en = ch_cfg[c].tx_period != 8'h00;
		// Period one fires on every backup, no history held
		assign tx_hit[c] = bk_hit[c] && tx_en && (tx_cnt_r >= ch_cfg[c].tx_period - 8'h01);
		// Threshold compare, one bit wider so sums cannot wrap
		assign lo_en = acq_en && ch_cfg[c].alarm_type[0];
		assign hi_en = acq_en && ch_cfg[c].alarm_type[1];
		assign v = {1'b0, ch_smp[c]};
		assign lo_top = {1'b0, ch_cfg[c].low_threshold} + {1'b0, ch_cfg[c].low_hysteresis};
		assign hi_bot = {1'b0, ch_cfg[c].high_threshold} - {1'b0, ch_cfg[c].high_hysteresis};
		assign lo_set = smp_ok && lo_en && !lo_alm_r && (ch_smp[c] < ch_cfg[c].low_threshold);
		assign lo_clr = smp_ok && lo_en && lo_alm_r && (v > lo_top);
		assign hi_set = smp_ok && hi_en && !hi_alm_r && (ch_smp[c] > ch_cfg[c].high_threshold);
		assign hi_clr = smp_ok && hi_en && hi_alm_r && !hi_bot[16] && (v < hi_bot);
		// Alarm frames go out alongside periodic ones
		assign alm_evt[c] = lo_set || lo_clr || hi_set || hi_clr;
		assign alm_act[c] = lo_alm_r || hi_alm_r;
		// Acquisition period register, loaded by software
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst)
				acq_r <= (c == 0) ? PRESS_ACQ_RST : ANALOG_ACQ_RST;
			else if (cfg_load)
				acq_r <= ch_acq_in[c];
		end
		// Pacing counters, cleared by the event they trigger
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				acq_cnt_r <= 16'h0000;
				bk_cnt_r <= 8'h00;
				tx_cnt_r <= 8'h00;
			end else begin
				if (!acq_en || acq_hit[c])
					acq_cnt_r <= 16'h0000;
				else if (tick_2s)
					acq_cnt_r <= acq_cnt_r + 16'h0001;
				if (bk_hit[c])
					bk_cnt_r <= 8'h00;
				else if (smp_ok)
					bk_cnt_r <= bk_cnt_r + 8'h01;
				if (tx_hit[c] || !tx_en)
					tx_cnt_r <= 8'h00;
				else if (bk_hit[c])
					tx_cnt_r <= tx_cnt_r + 8'h01;
			end
		end
		// Alarm state; disabling drops it without a frame
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				lo_alm_r <= 1'b0;
				hi_alm_r <= 1'b0;
			end else begin
				lo_alm_r <= lo_en && (lo_set || (lo_alm_r && !lo_clr));
				hi_alm_r <= hi_en && (hi_set || (hi_alm_r && !hi_clr));
			end
		end
	end
	// ----------------------------------------
	// Keep-alive and on-demand requests
	// ----------------------------------------
	logic [15:0] ka_cnt_r;
	logic [1:0] mag_sync_r;
	logic [11:0] mag_cnt_r;
	srs_mag_e mag_st_r;
	srs_mag_e mag_nxt;
	wire logic ka_en;
	wire logic ka_hit;
	wire logic dl_ka;
	wire logic mag_fire;
	assign ka_en = keepalive_period != 16'h0000;
	assign ka_hit = ka_en && tick_10s && (ka_cnt_r >= keepalive_period - 16'h0001);
	assign dl_ka = dl_valid && (dl_code == DL_KA_REQ);
	assign mag_fire = (mag_st_r == MAG_HOLD) && tick_ms && (mag_cnt_r == 12'(MAGNET_HOLD_MS - 1));
	// Keep-alive period in 10 s units
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			ka_cnt_r <= 16'h0000;
		else if (!ka_en || ka_hit)
			ka_cnt_r <= 16'h0000;
		else if (tick_10s)
			ka_cnt_r <= ka_cnt_r + 16'h0001;
	end
	// Magnet hold; one request per hold, re-armed on release
	always_comb begin
		mag_nxt = mag_st_r;
		case (mag_st_r)
			MAG_IDLE: if (mag_sync_r[1]) mag_nxt = MAG_HOLD;
			MAG_HOLD: begin
				if (!mag_sync_r[1])
					mag_nxt = MAG_IDLE;
				else if (mag_fire)
					mag_nxt = MAG_DONE;
			end
			MAG_DONE: if (!mag_sync_r[1]) mag_nxt = MAG_IDLE;
			default: mag_nxt = MAG_IDLE;
		endcase
	end
	// Magnet synchroniser, state and hold timer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mag_sync_r <= 2'h0;
			mag_st_r <= MAG_IDLE;
			mag_cnt_r <= 12'h000;
		end else begin
			mag_sync_r <= {mag_sync_r[0], magnet_in};
			mag_st_r <= mag_nxt;
			if (mag_st_r != MAG_HOLD)
				mag_cnt_r <= 12'h000;
			else if (tick_ms)
				mag_cnt_r <= mag_cnt_r + 12'h001;
		end
	end
	// ----------------------------------------
	// Digital terminals
	// ----------------------------------------
	wire logic [7:0] t_cfg [2];
	wire logic [7:0] t_num [2];
	wire logic [1:0] term_evt;
	assign t_cfg[0] = terminal_one_config;
	assign t_cfg[1] = terminal_two_config;
	assign t_num[0] = terminal_one_event_count;
	assign t_num[1] = terminal_two_event_count;

	for (genvar t = 0; t < 2; t++) begin : g_term
		logic [1:0] sync_r;
		logic stable_r;
		logic [9:0] deb_cnt_r;
		logic [7:0] evt_cnt_r;
		logic out_r;
		wire logic is_out;
		wire logic is_in;
		wire logic [9:0] deb_ms;
		wire logic changed;
		wire logic accept;
		wire logic rise;
		wire logic fall;
		wire logic qual;
		wire logic [7:0] evt_n;
		assign is_out = t_cfg[t] == TERM_OUT;
		assign is_in = (t_cfg[t] != TERM_OFF) && !is_out;
		assign deb_ms = (t_cfg[t][1:0] == 2'h0) ? DEB_MS_0 :
			(t_cfg[t][1:0] == 2'h1) ? DEB_MS_1 :
			(t_cfg[t][1:0] == 2'h2) ? DEB_MS_2 : DEB_MS_3;
		// Level must hold the whole debounce time before it counts
		assign changed = sync_r[1] != stable_r;
		assign accept = is_in && changed && ((deb_cnt_r >= deb_ms) ||
			(tick_ms && (deb_cnt_r + 10'h001 >= deb_ms)));
		assign rise = accept && sync_r[1];
		assign fall = accept && !sync_r[1];
		// 0x41 watches falling edges, 0x73 both directions
		assign qual = (t_cfg[t][5:4] == EDGE_FALL) ? fall :
			(t_cfg[t][5:4] == EDGE_RISE) ? rise : accept;
		assign evt_n = (t_num[t] == 8'h00) ? 8'h01 : t_num[t];
		// Edge-driven only, there is no timer path here
		assign term_evt[t] = qual && (evt_cnt_r >= evt_n - 8'h01);
		assign term_out[t] = out_r;
		assign term_oe[t] = is_out;

		// Input synchroniser and debounce filter
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				sync_r <= 2'h3; // Idle high with the pull-up, no false edge after reset
				stable_r <= 1'b1;
				deb_cnt_r <= 10'h000;
			end else begin
				sync_r <= {sync_r[0], term_in[t]};
				if (accept)
					stable_r <= sync_r[1];
				else if (!is_in)
					stable_r <= sync_r[1];
				if (!changed || accept)
					deb_cnt_r <= 10'h000;
				else if (tick_ms && deb_cnt_r != 10'h3ff)
					deb_cnt_r <= deb_cnt_r + 10'h001;
			end
		end

		// Edge counter and downlink-driven output level
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				evt_cnt_r <= 8'h00;
				out_r <= TERM_OUT_RST;
			end else begin
				if (!is_in || term_evt[t])
					evt_cnt_r <= 8'h00;
				else if (qual)
					evt_cnt_r <= evt_cnt_r + 8'h01;
				if (!is_out)
					out_r <= TERM_OUT_RST;
				else if (dl_out_valid && (dl_out_term == 1'(t)))
					out_r <= dl_out_state;
			end
		end
	end

	// ----------------------------------------
	// Frame requests and strobes
	// ----------------------------------------
	srs_frame_s frame_nxt;
	srs_frame_s frame_r;
	logic [1:0] acq_req_r;
	logic [1:0] backup_r;
	logic [1:0] alarm_r;
	wire logic ka_any;

	// Simultaneous causes share one flag word, so none is lost
	assign ka_any = ka_hit || dl_ka || mag_fire;
	assign frame_nxt.periodic = tx_hit;
	assign frame_nxt.alarm = alm_evt;
	assign frame_nxt.keepalive = ka_hit;
	assign frame_nxt.on_demand = dl_ka || mag_fire;
	assign frame_nxt.terminal = term_evt;
	assign frame_nxt.code = ka_any ? KA_CODE : DATA_CODE;

	// Registered outputs, one-cycle pulses except alarm level
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			frame_r <= '0;
			acq_req_r <= 2'h0;
			backup_r <= 2'h0;
			alarm_r <= 2'h0;
		end else begin
			frame_r <= frame_nxt;
			acq_req_r <= acq_hit;
			backup_r <= bk_hit;
			alarm_r <= alm_act;
		end
	end

	assign frame = frame_r;
	assign acq_req = acq_req_r;
	assign backup_strobe = backup_r;
	assign alarm_active = alarm_r;
endmodule : srs_top
`default_nettype wire

// ### include/srs_pkg.sv
// What this block does
// - Pressure acquisition period counts in 2 s units; 5400 gives one reading per 3 h.
// - Store one backup record after the configured number of acquisitions.
// - Send one periodic data frame after the configured number of backups.
// - Transmission period zero means no periodic frames, events only.
// - Analog acquisition period zero disables analog periodic reporting and alarms.
// - Transmission period one sends a frame at every backup, latest record only.
// - Frame on entering alarm and another frame on return to normal.
// - Alarm type zero disables alarms; type one selects low threshold.
// - Low alarm sets below threshold, clears above threshold plus hysteresis.
// - Periodic and alarm reporting work together on one channel.
// - Keep-alive frame code 0x30 every period in 10 s units.
// - Immediate keep-alive on downlink 0x05 or magnet held three seconds.
// - Terminal inputs ignore pulses shorter than their debounce time.
// - Terminal config 0x41 is single-edge detection, 100 ms debounce; zero disables.
// - Event count one sends a frame per qualified edge.
// - Event count N sends a frame once N qualified edges were seen.
// - Terminal inputs never produce periodic frames.
// - Terminal config 0x05 is an output, default closed, set by downlink.
// - Terminal config 0x73 counts rising and falling edges, one second guard.
// - Pressure acquisition period defaults to hourly readings.
package srs_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_KHZ = 125000;
	localparam int unsigned BASE_MS = 2000;
	localparam int unsigned KA_BASES = 5;
	localparam int unsigned MAGNET_HOLD_MS = 3000;
	// Debounce times in ms, picked by config bits 1:0
	localparam logic [9:0] DEB_MS_0 = 10'h000;
	localparam logic [9:0] DEB_MS_1 = 10'h064;
	localparam logic [9:0] DEB_MS_2 = 10'h00a;
	localparam logic [9:0] DEB_MS_3 = 10'h3e8;
	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [15:0] PRESS_ACQ_RST = 16'h0708;
	localparam logic [15:0] ANALOG_ACQ_RST = 16'h0000;
	localparam logic [7:0] KA_CODE = 8'h30;
	localparam logic [7:0] DATA_CODE = 8'h00;
	localparam logic [7:0] DL_KA_REQ = 8'h05;
	localparam logic [7:0] TERM_OFF = 8'h00;
	localparam logic [7:0] TERM_OUT = 8'h05;
	localparam logic TERM_OUT_RST = 1'b1;
	// Edge select, config bits 5:4
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] backup_count;
		logic [7:0] tx_period;
		logic [1:0] alarm_type;
		logic [15:0] high_threshold;
		logic [15:0] high_hysteresis;
		logic [15:0] low_threshold;
		logic [15:0] low_hysteresis;
	} srs_chan_cfg_s;
	typedef struct packed {
		logic [1:0] periodic;
		logic [1:0] alarm;
		logic keepalive;
		logic on_demand;
		logic [1:0] terminal;
		logic [7:0] code;
	} srs_frame_s;
	typedef enum logic [1:0] {MAG_IDLE, MAG_HOLD, MAG_DONE} srs_mag_e;
endpackage : srs_pkg

// ### bench/srs_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module srs_top_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [1:0] sample_valid,
	input wire logic [15:0] pressure_sample,
	input wire srs_pkg::srs_chan_cfg_s pressure_cfg,
	input wire logic dl_valid,
	input wire logic [7:0] dl_code,
	input wire logic [7:0] terminal_one_config,
	input wire logic [7:0] terminal_two_config,
	input wire logic [1:0] term_oe,
	input wire logic [1:0] backup_strobe,
	input wire logic [1:0] alarm_active,
	input wire srs_pkg::srs_frame_s frame
);
	import srs_pkg::*;
	logic [16:0] lo_clr;
	logic take;
	// Widened so threshold plus hysteresis cannot wrap
	assign lo_clr = {1'b0, pressure_cfg.low_threshold} + {1'b0, pressure_cfg.low_hysteresis};
	assign take = sample_valid[0] && !alarm_active[0];
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ----------------------------------------
	// Pressure channel and frames
	// ----------------------------------------
	a_backup_has_sample: assert property (backup_strobe[0] |-> $past(sample_valid[0]))
		else $error("backup without sample");
	a_periodic_on_backup: assert property (frame.periodic[0] |-> backup_strobe[0])
		else $error("periodic frame without backup");
	a_tx_zero_quiet: assert property (pressure_cfg.tx_period == 8'h00 |-> !frame.periodic[0])
		else $error("periodic frame with period zero");
	a_tx_one_every: assert property (backup_strobe[0] && pressure_cfg.tx_period == 8'h01 |-> frame.periodic[0])
		else $error("backup without frame at period one");
	a_alarm_off_quiet: assert property (pressure_cfg.alarm_type == 2'h0 |-> !frame.alarm[0] && !alarm_active[0])
		else $error("alarm while disabled");
	a_low_set: assert property (take && pressure_cfg.alarm_type == 2'h1 && pressure_sample < pressure_cfg.low_threshold
		|-> ##1 frame.alarm[0] ##1 alarm_active[0]) else $error("low alarm not raised");
	a_low_clear: assert property (sample_valid[0] && alarm_active[0] && pressure_cfg.alarm_type == 2'h1
		&& {1'b0, pressure_sample} > lo_clr |-> ##1 frame.alarm[0] ##1 !alarm_active[0]) else $error("low alarm not cleared");
	a_high_set: assert property (take && pressure_cfg.alarm_type == 2'h2 && pressure_sample > pressure_cfg.high_threshold
		|-> ##1 frame.alarm[0] ##1 alarm_active[0]) else $error("high alarm not raised");
	a_ondemand_reply: assert property (dl_valid && dl_code == DL_KA_REQ |-> ##1 frame.on_demand && frame.code == KA_CODE)
		else $error("no on-demand frame");
	a_keepalive_code: assert property (frame.keepalive |-> frame.code == KA_CODE)
		else $error("wrong keep-alive code");
	a_oe_follows: assert property (term_oe == {terminal_two_config == TERM_OUT, terminal_one_config == TERM_OUT})
		else $error("output enable wrong");
	c_periodic: cover property (frame.periodic[0]);
	c_alarm: cover property (frame.alarm[0]);
	c_ondemand: cover property (frame.on_demand);
	c_terminal: cover property (frame.terminal[0]);
endmodule : srs_top_chk
`default_nettype wire

// ### bench/srs_server.sv
`timescale 1ns/1ps
`default_nettype none
module srs_server (
	input wire logic clk,
	input wire srs_pkg::srs_frame_s frame,
	output logic dl_valid,
	output logic [7:0] dl_code,
	output logic dl_out_valid,
	output logic dl_out_term,
	output logic dl_out_state
);
	import srs_pkg::*;
	int ka_seen = 0;
	initial begin
		dl_valid = 1'b0;
		dl_code = 8'h00;
		dl_out_valid = 1'b0;
		dl_out_term = 1'b0;
		dl_out_state = 1'b0;
	end
	// Idle fields show the inverse, so stale data never looks valid
	task automatic send_code(input logic [7:0] c);
		@(posedge clk);
		dl_valid <= 1'b1;
		dl_code <= c;
		@(posedge clk);
		dl_valid <= 1'b0;
		dl_code <= ~c;
	endtask : send_code
	// Output level command for one terminal
	task automatic send_out(input logic t, input logic s);
		@(posedge clk);
		dl_out_valid <= 1'b1;
		dl_out_term <= t;
		dl_out_state <= s;
		@(posedge clk);
		dl_out_valid <= 1'b0;
		dl_out_term <= ~t;
		dl_out_state <= ~s;
	endtask : send_out
	// Count on-demand keep-alive frames received
	always @(posedge clk) if (frame.on_demand) ka_seen <= ka_seen + 1;
endmodule : srs_server
`default_nettype wire

// ### bench/srs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module srs_top_tb;
	import srs_pkg::*;
	localparam int unsigned CYC = 4;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic cfg_load = 1'b0;
	logic [15:0] pressure_acq_period = 16'h0001;
	logic [15:0] analog_acq_period = 16'h0000;
	logic [15:0] keepalive_period = 16'h0000;
	logic [7:0] terminal_one_config = 8'h00;
	logic [7:0] terminal_one_event_count = 8'h01;
	logic [7:0] terminal_two_config = 8'h00;
	logic [1:0] sample_valid = 2'h0;
	logic [15:0] pressure_sample = 16'h0000;
	logic [15:0] analog_sample = 16'h0000;
	logic magnet_in = 1'b0;
	logic t0 = 1'b1;
	srs_chan_cfg_s cfg = '0;
	wire logic dl_valid, dl_out_valid, dl_out_term, dl_out_state;
	wire logic [7:0] dl_code;
	wire logic [1:0] term_w;
	logic [1:0] term_out, term_oe, acq_req, backup_strobe, alarm_active;
	srs_frame_s frame;
	logic [1:0] lo = 2'h0;
	logic [1:0] hi = 2'h0;
	int nsmp [2];
	int bad_count = 0;
	int check_count = 0;
	int seed = 31859;
	int cyc = 0;
	int tcnt = 0;
	int n, n0;
	logic [15:0] corner [8] = '{16'd199, 16'd200, 16'd211, 16'd210, 16'd301, 16'd280, 16'd279, 16'd300};
	logic [7:0] bcs [4] = '{8'd2, 8'd1, 8'd1, 8'd3};
	logic [7:0] txs [4] = '{8'd4, 8'd1, 8'd0, 8'd2};
	logic [1:0] ats [4] = '{2'd0, 2'd1, 2'd2, 2'd3};
	// Terminal two reads back its own drive, else the pull-up
	assign term_w = {term_oe[1] ? term_out[1] : 1'b1, t0};
	srs_top #(.CYC_MS(CYC)) DUT (.clk, .nrst, .cfg_load, .pressure_acq_period, .analog_acq_period,
		.pressure_cfg(cfg), .analog_cfg(cfg), .keepalive_period, .terminal_one_config, .terminal_one_event_count,
		.terminal_two_config, .terminal_two_event_count(8'h01), .sample_valid, .pressure_sample, .analog_sample,
		.dl_valid, .dl_code, .dl_out_valid, .dl_out_term, .dl_out_state, .magnet_in, .term_in(term_w),
		.term_out, .term_oe, .acq_req, .backup_strobe, .alarm_active, .frame);
	srs_server srv (.clk, .frame, .dl_valid, .dl_code, .dl_out_valid, .dl_out_term, .dl_out_state);
	always #4 clk = ~clk;
	// Cycle ceiling and terminal frame count
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (frame.terminal[0]) tcnt <= tcnt + 1;
		if (cyc == 90000) begin
			bad_count = bad_count + 1;
			finish_test();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test();
		if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	// Fresh counters per pass; cfg_load also latches the acquisition periods
	task automatic do_reset(input logic [7:0] bc, input logic [7:0] tx, input logic [1:0] at, input logic ld);
		@(posedge clk);
		nrst <= 1'b0;
		cfg.backup_count <= bc;
		cfg.tx_period <= tx;
		cfg.alarm_type <= at;
		analog_acq_period <= {15'h0000, ld};
		lo = 2'h0;
		hi = 2'h0;
		nsmp = '{0, 0};
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		cfg_load <= 1'b1;
		@(posedge clk);
		cfg_load <= 1'b0;
	endtask : do_reset
	// Expected {alarm, periodic, backup} for one accepted sample
	function automatic logic [2:0] expect_sample(input int c, input logic [15:0] s);
		logic bk, pe, al;
		nsmp[c]++;
		bk = nsmp[c] % cfg.backup_count == 0;
		pe = bk && cfg.tx_period != 0 && (nsmp[c] / cfg.backup_count) % cfg.tx_period == 0;
		al = 1'b0;
		if (cfg.alarm_type[0] && (lo[c] ? s > cfg.low_threshold + cfg.low_hysteresis : s < cfg.low_threshold)) begin
			lo[c] = !lo[c];
			al = 1'b1;
		end
		if (cfg.alarm_type[1] && (hi[c] ? s < cfg.high_threshold - cfg.high_hysteresis : s > cfg.high_threshold)) begin
			hi[c] = !hi[c];
			al = 1'b1;
		end
		return {al, pe, bk};
	endfunction : expect_sample
	task automatic sample(input int c, input logic [15:0] s, input logic on);
		logic [2:0] e;
		e = on ? expect_sample(c, s) : 3'h0;
		@(posedge clk);
		sample_valid <= (c == 0) ? 2'h1 : 2'h2;
		pressure_sample <= s;
		analog_sample <= s;
		@(posedge clk);
		sample_valid <= 2'h0;
		#1;
		check({frame.alarm[c], frame.periodic[c], backup_strobe[c]}, e);
		@(posedge clk) #1;
		check(alarm_active[c], lo[c] | hi[c]);
	endtask : sample
	task automatic pulse(input int lo_len, input int hi_len);
		@(posedge clk) t0 <= 1'b0;
		repeat (lo_len) @(posedge clk);
		t0 <= 1'b1;
		repeat (hi_len) @(posedge clk);
	endtask : pulse
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		cfg.low_threshold = 16'd200;
		cfg.low_hysteresis = 16'd10;
		cfg.high_threshold = 16'd300;
		cfg.high_hysteresis = 16'd20;
		// Pass 0 leaves the analog channel off: its samples must be ignored
		for (int k = 0; k < 4; k++) begin
			do_reset(bcs[k], txs[k], ats[k], k != 0);
			for (int c = 0; c < 2; c++)
				for (int i = 0; i < 28; i++)
					sample(c, i < 8 ? corner[i] : 16'(150 + $unsigned($random(seed)) % 200), c == 0 || k != 0);
		end
		srv.send_code(8'h06);
		#1;
		check(frame.on_demand, 1'b0);
		srv.send_code(DL_KA_REQ);
		#1;
		check({frame.on_demand, frame.code}, {1'b1, KA_CODE});
		@(posedge clk) terminal_two_config <= TERM_OUT;
		@(posedge clk) #1;
		check({term_oe, term_out}, {2'b10, 2'b11});
		srv.send_out(1'b1, 1'b0);
		@(posedge clk) #1;
		check(term_out, 2'b01);
		@(posedge clk) terminal_two_config <= TERM_OFF;
		repeat (2) @(posedge clk);
		check(term_out, 2'b11);
		// Debounce: a short dip is dropped, a long one counted
		@(posedge clk) terminal_one_config <= 8'h41;
		n0 = tcnt;
		pulse(200, 500);
		check(16'(tcnt - n0), 16'd0);
		pulse(500, 500);
		check(16'(tcnt - n0), 16'd1);
		@(posedge clk) terminal_one_config <= 8'h42;
		terminal_one_event_count <= 8'd3;
		repeat (6) pulse(60, 60);
		check(16'(tcnt - n0), 16'd3);
		@(posedge clk) terminal_one_config <= 8'h73;
		terminal_one_event_count <= 8'd1;
		pulse(4500, 4500);
		check(16'(tcnt - n0), 16'd5);
		@(posedge clk) terminal_one_config <= TERM_OFF;
		pulse(500, 500);
		check(16'(tcnt - n0), 16'd5);
		n0 = srv.ka_seen;
		@(posedge clk) magnet_in <= 1'b1;
		repeat (13000) @(posedge clk);
		magnet_in <= 1'b0;
		check(16'(srv.ka_seen - n0), 16'd1);
		@(posedge clk) keepalive_period <= 16'h0001;
		n = 0;
		while (acq_req[0] !== 1'b1 && n < 9000) begin
			@(posedge clk) #1;
			n++;
		end
		n = 0;
		do begin
			@(posedge clk) #1;
			n++;
		end while (acq_req[0] !== 1'b1 && n < 20000);
		check(16'(n), 16'(2000 * CYC));
		n = 0;
		while (frame.keepalive !== 1'b1 && n < 45000) begin
			@(posedge clk) #1;
			n++;
		end
		check({frame.keepalive, frame.code}, {1'b1, KA_CODE});
		finish_test();
	end
endmodule : srs_top_tb
bind srs_top srs_top_chk u_chk (.clk, .nrst, .sample_valid, .pressure_sample, .pressure_cfg, .dl_valid, .dl_code,
	.terminal_one_config, .terminal_two_config, .term_oe, .backup_strobe, .alarm_active, .frame);
`default_nettype wire
